// ==== include/scs_defs.vh ====
// Constants for the system clock switch controller.
// Assumes inclusion by bare name from logic files; definitions only.
`ifndef SCS_DEFS_VH
`define SCS_DEFS_VH

// Source codes of the next/current oscillator fields
`define SCS_SRC_W        3
`define SCS_SRC_FRC      3'h0
`define SCS_SRC_FAST_RC_WITH_PLL   3'h1
`define SCS_SRC_PRI      3'h2
`define SCS_SRC_PRIPLL   3'h3
`define SCS_SRC_SEC      3'h4
`define SCS_SRC_LOW_POWER_RC_SOURCE     3'h5

// One-hot source enable positions
`define SCS_EN_W         4
`define SCS_EN_PRI       0
`define SCS_EN_SEC       1
`define SCS_EN_FRC       2
`define SCS_EN_LOW_POWER_RC_SOURCE      3

// Unlock key pair
`define SCS_KEY1         8'h55
`define SCS_KEY2         8'hAA

// Last count of new clock ticks; the tenth tick starts the change-over
`define SCS_NEW_CYCLES   4'h9
`define SCS_CNT_ZERO     4'h0

// Switch sequencer states
`define SCS_ST_IDLE      3'h0
`define SCS_ST_START     3'h1
`define SCS_ST_OST       3'h2
`define SCS_ST_PLL       3'h3
`define SCS_ST_COUNT     3'h4
`define SCS_ST_DONE      3'h5

`endif

// ==== logic/scs_clock_switch.v ====
// System clock switch controller: unlock-protected writes, switch sequencer.
// Assumes source-ready and new-clock ticks arrive asynchronously as levels.
`timescale 1ns/100ps
`default_nettype none
`include "scs_defs.vh"
module scs_clock_switch (
    input  wire       clk_sys,          // System clock
    input  wire       sys_rst,          // Synchronous reset, high
    input  wire       switchMonitorFuseBit, // Fuse: 0 enables switching
    input  wire [2:0] resetOscSelectFuses,  // Fuse: source while switching is disabled
    input  wire       watchdogTimerOn,  // Watchdog uses LOW_POWER_RC_SOURCE
    input  wire       unlockKey,        // Key byte strobe
    input  wire [7:0] unlockData,       // Key byte value
    input  wire       wrHigh,           // Write strobe high byte
    input  wire       wrLow,            // Write strobe low byte
    input  wire [2:0] wrNextOscSelect,  // High-byte data: next source
    input  wire       wrOscSwitchRequest, // Low-byte data: request
    input  wire       wrSecondaryOscEnable, // Low-byte data: sec enable
    input  wire       wrSelectionLockBit,   // Low-byte data: lock
    input  wire       wrClockFailFlag,  // Low-byte data: fail flag
    input  wire       clockFailEvent,   // Fail-safe monitor detected failure
    input  wire       oscStartupDone,   // Startup timer expired (async)
    input  wire       pllLockIn,        // PLL lock detect (async)
    input  wire       newClockLevel,    // Target clock level (async)
    output reg  [2:0] currentOscSelect, // Active source
    output reg  [2:0] nextOscSelect,    // Requested source
    output reg        oscSwitchRequest, // Switch in progress
    output reg        pllLockStatus,    // PLL lock status
    output reg        clockFailFlag,    // Clock fail detected
    output reg        secondaryOscEnable, // Secondary keep-on
    output reg        selectionLockBit, // Selection lock
    output reg  [3:0] sourceEnable,     // Oscillator enables, one bit per source
    output reg        pllEnable,        // PLL enable
    output reg  [2:0] sysClockSelect    // Mux select for system clock
);
    // Source code to enable position
    function [3:0] srcOneHot;
        input [2:0] src;
        begin
            srcOneHot = 4'h0;
            case (src)
                `SCS_SRC_PRI, `SCS_SRC_PRIPLL: srcOneHot[`SCS_EN_PRI] = 1'b1;
                `SCS_SRC_SEC:  srcOneHot[`SCS_EN_SEC]  = 1'b1;
                `SCS_SRC_LOW_POWER_RC_SOURCE: srcOneHot[`SCS_EN_LOW_POWER_RC_SOURCE] = 1'b1;
                default:       srcOneHot[`SCS_EN_FRC]  = 1'b1;
            endcase
        end
    endfunction

    function usesPll;
        input [2:0] src;
        begin
            usesPll = (src == `SCS_SRC_FAST_RC_WITH_PLL) || (src == `SCS_SRC_PRIPLL);
        end
    endfunction

    localparam ST_IDLE  = `SCS_ST_IDLE;
    localparam ST_START = `SCS_ST_START;
    localparam ST_OST   = `SCS_ST_OST;
    localparam ST_PLL   = `SCS_ST_PLL;
    localparam ST_COUNT = `SCS_ST_COUNT;
    localparam ST_DONE  = `SCS_ST_DONE;

    reg  [2:0] state_ff;
    reg        keySeen_ff;
    reg        unlocked_ff;
    reg  [3:0] cycCnt_ff;
    wire       switchEnabled;
    wire       frozen;
    wire       ostLevel;
    wire       lockLevel;
    wire       newTick;
    wire       writeHighOk;
    wire       writeLowOk;
    wire [3:0] targetOneHot;

    assign switchEnabled = !switchMonitorFuseBit;
    assign frozen        = switchEnabled && selectionLockBit;
    assign writeHighOk   = wrHigh && unlocked_ff;
    assign writeLowOk    = wrLow && unlocked_ff && !wrHigh;
    // Decoded target once; a function result cannot be bit-selected
    assign targetOneHot  = srcOneHot(nextOscSelect);

    scs_edge_sync uOst (
        .clk_sys  (clk_sys),
        .sys_rst  (sys_rst),
        .asyncIn  (oscStartupDone),
        .levelOut (ostLevel),
        .riseOut  ()
    );
    scs_edge_sync uLock (
        .clk_sys  (clk_sys),
        .sys_rst  (sys_rst),
        .asyncIn  (pllLockIn),
        .levelOut (lockLevel),
        .riseOut  ()
    );
    // New clock sampled; only for counting its rising edges
    scs_edge_sync uTick (
        .clk_sys  (clk_sys),
        .sys_rst  (sys_rst),
        .asyncIn  (newClockLevel),
        .levelOut (),
        .riseOut  (newTick)
    );

    // Unlock: two key bytes arm exactly one byte write
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            keySeen_ff  <= 1'b0;
            unlocked_ff <= 1'b0;
        end else if (wrHigh || wrLow) begin
            keySeen_ff  <= 1'b0;
            unlocked_ff <= 1'b0;
        end else if (unlockKey) begin
            keySeen_ff  <= (unlockData == `SCS_KEY1);
            unlocked_ff <= keySeen_ff && (unlockData == `SCS_KEY2);
        end
    end

    // Register fields and switch sequencer
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            state_ff           <= ST_IDLE;
            cycCnt_ff          <= `SCS_CNT_ZERO;
            currentOscSelect   <= `SCS_SRC_FRC;
            nextOscSelect      <= `SCS_SRC_FRC;
            oscSwitchRequest   <= 1'b0;
            pllLockStatus      <= 1'b0;
            clockFailFlag      <= 1'b0;
            secondaryOscEnable <= 1'b0;
            selectionLockBit   <= 1'b0;
            sourceEnable       <= 4'h0;
            pllEnable          <= 1'b0;
            sysClockSelect     <= `SCS_SRC_FRC;
        end else begin
            // Fuse source reloaded every cycle while switching is disabled
            if (!switchEnabled) begin
                currentOscSelect <= resetOscSelectFuses;
                nextOscSelect    <= resetOscSelectFuses;
                sysClockSelect   <= resetOscSelectFuses;
                oscSwitchRequest <= 1'b0;
                selectionLockBit <= 1'b0;
                sourceEnable     <= srcOneHot(resetOscSelectFuses) |
                                    {watchdogTimerOn, 1'b0, secondaryOscEnable, 1'b0};
                pllEnable        <= usesPll(resetOscSelectFuses);
                pllLockStatus    <= usesPll(resetOscSelectFuses) && lockLevel;
                state_ff         <= ST_IDLE;
            end
            // Byte writes; primary submode comes only from fuses
            if (writeHighOk && switchEnabled && !frozen && state_ff == ST_IDLE) begin
                nextOscSelect <= wrNextOscSelect;
            end
            if (writeLowOk) begin
                secondaryOscEnable <= wrSecondaryOscEnable;
                if (switchEnabled && !selectionLockBit) begin
                    selectionLockBit <= wrSelectionLockBit;
                end
                // Software clear of fail flag loses to an event
                if (!wrClockFailFlag) begin
                    clockFailFlag <= 1'b0;
                end
                if (switchEnabled && !frozen && wrOscSwitchRequest && state_ff == ST_IDLE) begin
                    oscSwitchRequest <= 1'b1;
                    state_ff         <= ST_START;
                end
            end
            if (switchEnabled) begin
                // Old source keeps clocking the system until DONE
                case (state_ff)
                    ST_IDLE: begin
                        pllLockStatus <= pllEnable && lockLevel;
                    end
                    ST_START: begin
                        if (nextOscSelect == currentOscSelect) begin
                            oscSwitchRequest <= 1'b0;
                            state_ff         <= ST_IDLE;
                        end else begin
                            pllLockStatus <= 1'b0;
                            clockFailFlag <= 1'b0;
                            sourceEnable  <= sourceEnable | srcOneHot(nextOscSelect);
                            pllEnable     <= usesPll(nextOscSelect);
                            state_ff      <= ST_OST;
                        end
                    end
                    ST_OST: begin
                        // Crystal waits; others pass; stall here if never ready
                        if (!targetOneHot[`SCS_EN_PRI] || ostLevel) begin
                            state_ff <= ST_PLL;
                        end
                    end
                    ST_PLL: begin
                        if (!usesPll(nextOscSelect) || lockLevel) begin
                            pllLockStatus <= usesPll(nextOscSelect);
                            cycCnt_ff     <= `SCS_CNT_ZERO;
                            state_ff      <= ST_COUNT;
                        end
                    end
                    ST_COUNT: begin
                        if (newTick) begin
                            if (cycCnt_ff == `SCS_NEW_CYCLES) begin
                                state_ff <= ST_DONE;
                            end
                            cycCnt_ff <= cycCnt_ff + 4'h1;
                        end
                    end
                    ST_DONE: begin
                        sysClockSelect   <= nextOscSelect;
                        currentOscSelect <= nextOscSelect;
                        oscSwitchRequest <= 1'b0;
                        sourceEnable     <= srcOneHot(nextOscSelect) |
                            {watchdogTimerOn, 1'b0, secondaryOscEnable, 1'b0};
                        state_ff         <= ST_IDLE;
                    end
                    default: state_ff <= ST_IDLE;
                endcase
            end
            // Failure event last, so it wins over every clear
            if (clockFailEvent && switchEnabled) begin
                clockFailFlag <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ==== logic/scs_edge_sync.v ====
// Three-stage synchroniser with edge detect for an outside-domain level.
// Assumes the input is asynchronous to clk_sys.
`timescale 1ns/100ps
`default_nettype none
module scs_edge_sync (
    input  wire clk_sys,   // System clock
    input  wire sys_rst,   // Synchronous reset, high
    input  wire asyncIn,   // Level from outside
    output reg  levelOut,  // Settled level
    output reg  riseOut    // One-cycle pulse on settled rise
);
    reg syncA_ff;
    reg syncB_ff;
    reg syncC_ff;

    // First stage feeds only the second
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            syncA_ff <= 1'b0;
            syncB_ff <= 1'b0;
            syncC_ff <= 1'b0;
            levelOut <= 1'b0;
            riseOut  <= 1'b0;
        end else begin
            syncA_ff <= asyncIn;
            syncB_ff <= syncA_ff;
            syncC_ff <= syncB_ff;
            // Change counts only when stages two and three agree
            riseOut  <= (syncB_ff == syncC_ff) && syncC_ff && !levelOut;
            if (syncB_ff == syncC_ff) begin
                levelOut <= syncC_ff;
            end
        end
    end
endmodule
`default_nettype wire

// ==== sim/scs_switch_properties.sv ====
// Port checker for the clock switch controller.
// Assumes a bind onto scs_clock_switch; one clock.
`timescale 1ns/100ps
`default_nettype none
module scs_switch_properties (
    input wire logic       clk_sys,              // Clock
    input wire logic       sys_rst,              // Reset
    input wire logic       switchMonitorFuseBit, // Fuse
    input wire logic [2:0] resetOscSelectFuses,  // Reset source
    input wire logic       newClockLevel,        // New clock
    input wire logic [2:0] currentOscSelect,     // Active
    input wire logic [2:0] nextOscSelect,        // Requested
    input wire logic       oscSwitchRequest,     // Request
    input wire logic       pllLockStatus,        // Lock
    input wire logic       clockFailFlag,        // Fail
    input wire logic [2:0] sysClockSelect        // Mux select
);
    logic [3:0] tickCnt_ff;
    logic [3:0] nxt_tickCnt;
    logic       lvlPrev_ff;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    // Raw edges during a switch; sync lag only lowers the design's count
    always_comb begin
        nxt_tickCnt = 4'h0;
        if (oscSwitchRequest) begin
            nxt_tickCnt = tickCnt_ff + {3'h0, newClockLevel & ~lvlPrev_ff & (tickCnt_ff != 4'hf)};
        end
    end
    // Edge history and counter
    always_ff @(posedge clk_sys) begin
        lvlPrev_ff <= newClockLevel;
        tickCnt_ff <= sys_rst ? 4'h0 : nxt_tickCnt;
    end
    sequence reqStart;
        $rose(oscSwitchRequest) && (currentOscSelect != nextOscSelect);
    endsequence
    sequence swDone;
        $fell(oscSwitchRequest) && (currentOscSelect != $past(currentOscSelect));
    endsequence
    a_fuse_no_req: assert property (switchMonitorFuseBit |-> !oscSwitchRequest)
        else $error("request set while disabled");
    a_fuse_sets_cur: assert property ((switchMonitorFuseBit && $stable(resetOscSelectFuses)) [*3]
        |-> currentOscSelect == resetOscSelectFuses && sysClockSelect == resetOscSelectFuses)
        else $error("selection not from fuses");
    a_redundant_abort: assert property ($rose(oscSwitchRequest) && currentOscSelect == nextOscSelect
        |=> $stable(currentOscSelect) [*3] ##0 !oscSwitchRequest)
        else $error("redundant switch not aborted");
    a_start_clears: assert property (reqStart |-> ##[1:3] (!pllLockStatus && !clockFailFlag))
        else $error("lock or fail not cleared");
    a_old_clock_holds: assert property (oscSwitchRequest && $past(oscSwitchRequest)
        |-> $stable(sysClockSelect))
        else $error("clock moved during switch");
    a_done_copies: assert property (swDone |-> currentOscSelect == $past(nextOscSelect)
        && sysClockSelect == currentOscSelect)
        else $error("next not copied at switch end");
    a_ten_ticks: assert property (swDone |-> tickCnt_ff >= 4'ha)
        else $error("switched before ten new clocks");
    a_pll_waited: assert property ((swDone and (currentOscSelect inside {3'h1, 3'h3}))
        |-> $past(pllLockStatus))
        else $error("PLL target switched unlocked");
endmodule
`default_nettype wire

// ==== sim/tb_scs_clock_switch.sv ====
// Bench for the clock switch controller: unlock and byte writes.
// Assumes design and checker compiled first.
`timescale 1ns/100ps
`default_nettype none
module tb_scs_clock_switch;
    logic       clk_sys, sys_rst, switchMonitorFuseBit, watchdogTimerOn, unlockKey, wrHigh, wrLow;
    logic       wrOscSwitchRequest, wrSecondaryOscEnable, wrSelectionLockBit, wrClockFailFlag;
    logic       clockFailEvent, oscStartupDone, pllLockIn, newClockLevel, oscSwitchRequest;
    logic       pllLockStatus, clockFailFlag, secondaryOscEnable, selectionLockBit, pllEnable;
    logic [7:0] unlockData;
    logic [3:0] sourceEnable;
    logic [2:0] resetOscSelectFuses, wrNextOscSelect, currentOscSelect, nextOscSelect, sysClockSelect;
    int         error_cnt, total_checks, cycles;
    scs_clock_switch u_scs_clock_switch (
        .clk_sys              (clk_sys),
        .sys_rst              (sys_rst),
        .switchMonitorFuseBit (switchMonitorFuseBit),
        .resetOscSelectFuses  (resetOscSelectFuses),
        .watchdogTimerOn      (watchdogTimerOn),
        .unlockKey            (unlockKey),
        .unlockData           (unlockData),
        .wrHigh               (wrHigh),
        .wrLow                (wrLow),
        .wrNextOscSelect      (wrNextOscSelect),
        .wrOscSwitchRequest   (wrOscSwitchRequest),
        .wrSecondaryOscEnable (wrSecondaryOscEnable),
        .wrSelectionLockBit   (wrSelectionLockBit),
        .wrClockFailFlag      (wrClockFailFlag),
        .clockFailEvent       (clockFailEvent),
        .oscStartupDone       (oscStartupDone),
        .pllLockIn            (pllLockIn),
        .newClockLevel        (newClockLevel),
        .currentOscSelect     (currentOscSelect),
        .nextOscSelect        (nextOscSelect),
        .oscSwitchRequest     (oscSwitchRequest),
        .pllLockStatus        (pllLockStatus),
        .clockFailFlag        (clockFailFlag),
        .secondaryOscEnable   (secondaryOscEnable),
        .selectionLockBit     (selectionLockBit),
        .sourceEnable         (sourceEnable),
        .pllEnable            (pllEnable),
        .sysClockSelect       (sysClockSelect)
    );
    // Clock, 8 ns
    always #4 clk_sys = ~clk_sys;
    // Hang guard, far above the run length
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            error_cnt++;
            give_verdict();
        end
    end
    task automatic chk(input string n, input logic [3:0] e, input logic [3:0] g);
        total_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic give_verdict();
        if (error_cnt == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // Key pair (if u) then one byte write; low byte d = lock, sec, request
    task automatic wr(input logic hi, input logic [2:0] d, input logic u);
        @(posedge clk_sys);
        unlockKey <= u;
        unlockData <= 8'h55;
        @(posedge clk_sys);
        unlockData <= 8'hAA;
        @(posedge clk_sys);
        unlockKey <= 1'b0;
        wrHigh <= hi;
        wrLow <= ~hi;
        wrNextOscSelect <= d;
        {wrSelectionLockBit, wrSecondaryOscEnable, wrOscSwitchRequest} <= d;
        @(posedge clk_sys);
        wrHigh <= 1'b0;
        wrLow <= 1'b0;
        repeat (2) @(posedge clk_sys);
        #1;
    endtask
    // Slow new clock, wide enough for the synchroniser
    task automatic tick(input int n);
        @(posedge clk_sys);
        repeat (n) begin
            newClockLevel <= 1'b1;
            repeat (4) @(posedge clk_sys);
            newClockLevel <= 1'b0;
            repeat (4) @(posedge clk_sys);
        end
    endtask
    task automatic wait_done();
        for (int i = 0; i < 300 && oscSwitchRequest !== 1'b0; i++) @(posedge clk_sys);
        #1;
        chk("request", 4'h0, {3'h0, oscSwitchRequest});
    endtask
    task automatic do_reset(input logic fuse);
        @(posedge clk_sys);
        sys_rst <= 1'b1;
        switchMonitorFuseBit <= fuse;
        repeat (16) @(posedge clk_sys);
        sys_rst <= 1'b0;
        repeat (3) @(posedge clk_sys);
        #1;
    endtask
    task automatic pause(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    initial begin
        {clk_sys, unlockKey, unlockData, wrHigh, wrLow, wrNextOscSelect} = '0;
        {wrOscSwitchRequest, wrSecondaryOscEnable, wrSelectionLockBit, clockFailEvent} = '0;
        {oscStartupDone, pllLockIn, newClockLevel, watchdogTimerOn} = '0;
        wrClockFailFlag = 1'b1;
        resetOscSelectFuses = 3'h2;
        sys_rst = 1'b1;
        switchMonitorFuseBit = 1'b1;
        do_reset(1'b1);
        chk("current", 4'h2, currentOscSelect);
        wr(1'b1, 3'h4, 1'b1);
        wr(1'b0, 3'h1, 1'b1);
        chk("request", 4'h0, oscSwitchRequest);
        chk("clock sel", 4'h2, sysClockSelect);
        do_reset(1'b0);
        chk("current", 4'h0, currentOscSelect);
        wr(1'b1, 3'h4, 1'b0);
        chk("next", 4'h0, nextOscSelect);
        wr(1'b1, 3'h4, 1'b1);
        chk("next", 4'h4, nextOscSelect);
        @(posedge clk_sys);
        clockFailEvent <= 1'b1;
        @(posedge clk_sys);
        clockFailEvent <= 1'b0;
        pause(1);
        chk("fail", 4'h1, clockFailFlag);
        wr(1'b0, 3'h3, 1'b1);
        pause(3);
        chk("fail", 4'h0, clockFailFlag);
        pause(20);
        chk("request", 4'h1, oscSwitchRequest);
        chk("clock sel", 4'h0, sysClockSelect);
        tick(9);
        pause(8);
        chk("current", 4'h0, currentOscSelect);
        tick(1);
        wait_done();
        chk("current", 4'h4, currentOscSelect);
        chk("clock sel", 4'h4, sysClockSelect);
        chk("enables", 4'h2, sourceEnable);
        wr(1'b0, 3'h3, 1'b1);
        pause(2);
        chk("request", 4'h0, oscSwitchRequest);
        wr(1'b1, 3'h3, 1'b1);
        wr(1'b0, 3'h3, 1'b1);
        pause(30);
        chk("request", 4'h1, oscSwitchRequest);
        chk("enables", 4'h3, sourceEnable);
        @(posedge clk_sys);
        oscStartupDone <= 1'b1;
        watchdogTimerOn <= 1'b1;
        pause(30);
        chk("request", 4'h1, oscSwitchRequest);
        @(posedge clk_sys);
        pllLockIn <= 1'b1;
        pause(10);
        chk("lock", 4'h1, pllLockStatus);
        tick(10);
        wait_done();
        chk("current", 4'h3, currentOscSelect);
        chk("enables", 4'hb, sourceEnable);
        chk("pll", 4'h1, pllEnable);
        wr(1'b0, 3'h4, 1'b1);
        chk("sel lock", 4'h1, selectionLockBit);
        chk("sec en", 4'h0, secondaryOscEnable);
        wr(1'b1, 3'h0, 1'b1);
        chk("next", 4'h3, nextOscSelect);
        give_verdict();
    end
endmodule
bind scs_clock_switch scs_switch_properties u_scs_switch_properties (
    .clk_sys              (clk_sys),
    .sys_rst              (sys_rst),
    .switchMonitorFuseBit (switchMonitorFuseBit),
    .resetOscSelectFuses  (resetOscSelectFuses),
    .newClockLevel        (newClockLevel),
    .currentOscSelect     (currentOscSelect),
    .nextOscSelect        (nextOscSelect),
    .oscSwitchRequest     (oscSwitchRequest),
    .pllLockStatus        (pllLockStatus),
    .clockFailFlag        (clockFailFlag),
    .sysClockSelect       (sysClockSelect)
);
`default_nettype wire
